// [design/flash_cmd_seq.sv]
// command decoder and self-timed program/erase sequencer of a serial nor flash
`timescale 1ns/10ps
module flash_cmd_seq #(
	parameter int unsigned PROG_CYC = flash_seq_pkg::PROG_CYC_DEF,
	parameter int unsigned SECT_CYC = flash_seq_pkg::SECT_CYC_DEF,
	parameter int unsigned BLK_CYC  = flash_seq_pkg::BLK_CYC_DEF
) (
	input  wire logic                      mclk,
	input  wire logic                      rst_b,
	input  wire flash_seq_pkg::link_pins_t link_pins,
	input  wire logic                      quad_enable_flag,
	input  wire logic                      four_wire_cmd_mode,
	input  wire logic [4:0]                block_guard,
	output logic                           write_latch_flag,
	output logic                           op_in_progress,
	output flash_seq_pkg::wrap_cfg_t       wrap_cfg,
	output flash_seq_pkg::array_op_t       array_op,
	output logic                           prog_we,
	output logic [23:0]                    prog_addr,
	output logic [7:0]                     prog_data
);
	import flash_seq_pkg::*;

	typedef enum logic [2:0] {
		S_IDLE,
		S_CMD,
		S_ADDR,
		S_DATA,
		S_TAIL,
		S_SKIP
	} frame_state_t;

	// ====================================================
	// synchronised link
	logic       sclk_rise;
	logic       sel_fall;
	logic       sel_rise;
	logic       sel;
	logic [3:0] io_s;

	link_sync u_sync (
		.mclk      (mclk),
		.rst_b     (rst_b),
		.pins      (link_pins),
		.sclk_rise (sclk_rise),
		.sel_fall  (sel_fall),
		.sel_rise  (sel_rise),
		.sel       (sel),
		.io_s      (io_s)
	);

	// ====================================================
	// state
	frame_state_t          state_reg, state_next;
	logic [7:0]            shift_reg, shift_next;
	logic [2:0]            bit_reg, bit_next;
	logic [7:0]            op_reg, op_next;
	logic [23:0]           addr_reg, addr_next;
	logic [1:0]            acnt_reg, acnt_next;
	logic [7:0]            ofs_reg, ofs_next;
	logic                  seen_reg, seen_next;
	logic [7:0]            param_reg, param_next;
	logic [PAGE_BYTES-1:0] mask_reg, mask_next;
	logic                  wel_reg, wel_next;
	logic                  busy_reg, busy_next;
	op_kind_t              kind_reg, kind_next;
	logic [31:0]           tmr_reg, tmr_next;
	logic [8:0]            sidx_reg, sidx_next;
	logic                  rd_live_reg, rd_live_next;
	logic [7:0]            rd_idx_reg, rd_idx_next;
	wrap_cfg_t             wrap_reg, wrap_next;
	array_op_t             aop_reg, aop_next;
	logic                  pwe_reg, pwe_next;
	logic [23:0]           padr_reg, padr_next;

	// ====================================================
	// buffer ports and shift helpers
	logic       buf_we;
	logic [7:0] buf_wa;
	logic       wide;
	logic [7:0] shifted;
	logic [2:0] bit_inc;
	logic       byte_done;
	logic       on_bound;

	// guarded region: low three bits give size as a power of two of the grain,
	// bit 3 moves the region from top to bottom, bit 4 picks the small grain
	function automatic logic guarded(input logic [23:0] a, input logic [4:0] g);
		logic [24:0] size;
		logic [24:0] grain;
		grain = g[4] ? (25'h1 << SECT_BITS) : (25'h1 << GUARD_BIG_BITS);
		size  = grain << (g[2:0] - 3'h1);
		if (g[2:0] == 3'h0) begin
			guarded = 1'b0;
		end else if (g[2:0] == 3'h7) begin
			guarded = 1'b1;
		end else if (g[3]) begin
			guarded = {1'b0, a} < size;
		end else begin
			guarded = {1'b0, a} >= (25'h1000000 - size);
		end
	endfunction

	// aligned span check: either end guarded refuses the whole span
	function automatic logic span_guarded(input logic [23:0] a, input int bits,
	                                      input logic [4:0] g);
		logic [23:0] lo;
		logic [23:0] hi;
		lo = a & ~((24'h1 << bits) - 24'h1);
		hi = lo | ((24'h1 << bits) - 24'h1);
		span_guarded = guarded(lo, g) | guarded(hi, g);
	endfunction

	// address and data of quad program, and every phase in four-wire mode, take a nibble
	// quad data lines
	assign wide      = four_wire_cmd_mode | (state_reg != S_CMD && op_reg == OP_QUAD_WRITE);
	assign shifted   = wide ? {shift_reg[3:0], io_s} : {shift_reg[6:0], io_s[0]};
	assign bit_inc   = wide ? 3'h4 : 3'h1;
	assign byte_done = (bit_reg + bit_inc) == 3'h0;
	assign on_bound  = bit_reg == 3'h0;
	assign buf_wa    = addr_reg[7:0] + ofs_reg;

	// ====================================================
	// next-state logic for frame decode and timed cycles
	always_comb begin
		state_next   = state_reg;
		shift_next   = shift_reg;
		bit_next     = bit_reg;
		op_next      = op_reg;
		addr_next    = addr_reg;
		acnt_next    = acnt_reg;
		ofs_next     = ofs_reg;
		seen_next    = seen_reg;
		param_next   = param_reg;
		mask_next    = mask_reg;
		wel_next     = wel_reg;
		busy_next    = busy_reg;
		kind_next    = kind_reg;
		tmr_next     = tmr_reg;
		sidx_next    = sidx_reg;
		rd_live_next = 1'b0;
		rd_idx_next  = rd_idx_reg;
		wrap_next    = wrap_reg;
		aop_next     = aop_reg;
		aop_next.start = 1'b0;
		pwe_next     = 1'b0;
		padr_next    = padr_reg;
		buf_we       = 1'b0;

		// frame opens: counters restart; the page mask waits for an opcode byte that arrives while not busy
		if (sel_fall) begin
			state_next = S_CMD;
			bit_next   = 3'h0;
			acnt_next  = 2'h0;
			ofs_next   = 8'h0;
			seen_next  = 1'b0;
		end else if (sel && sclk_rise && state_reg != S_IDLE) begin
			shift_next = shifted;
			bit_next   = bit_reg + bit_inc;
			case (state_reg)
				S_CMD: begin
					if (byte_done) begin
						op_next = shifted;
						// while busy every frame is ignored; the busy flag is a pin
						if (busy_reg) begin
							state_next = S_SKIP;
						end else begin
							// a frame opened during a cycle must not wipe the marks still being programmed
							mask_next = '0;
							case (shifted)
								OP_WR_UNLOCK,
								OP_WR_LOCK: state_next = S_TAIL;
								OP_QUAD_WRITE: state_next = quad_enable_flag ? S_ADDR : S_SKIP;
								OP_PAGE_WRITE,
								OP_SECT_CLEAR,
								OP_BLK_CLEAR,
								OP_WRAP_SET: state_next = S_ADDR;
								// parameter frame only in four-wire mode
								OP_READ_PARAM: state_next = four_wire_cmd_mode ? S_DATA : S_SKIP;
								default: state_next = S_SKIP;
							endcase
						end
					end
				end
				S_ADDR: begin
					if (byte_done) begin
						addr_next = {addr_reg[15:0], shifted};
						acnt_next = acnt_reg + 2'h1;
						// three dummy bytes before the wrap byte
						if (acnt_reg == 2'(ADDR_BYTES - 1)) begin
							case (op_reg)
								OP_SECT_CLEAR,
								OP_BLK_CLEAR: state_next = S_TAIL;
								default: state_next = S_DATA;
							endcase
						end
					end
				end
				S_DATA: begin
					if (byte_done) begin
						if (op_reg == OP_WRAP_SET || op_reg == OP_READ_PARAM) begin
							param_next = shifted;
							state_next = S_TAIL;
						end else begin
							// later bytes overwrite earlier ones in the ring
							buf_we    = 1'b1;
							mask_next[buf_wa] = 1'b1;
							ofs_next  = ofs_reg + 8'h1;
							seen_next = 1'b1;
						end
					end
				end
				// any bit past the expected end spoils the frame
				S_TAIL: state_next = S_SKIP;
				default: state_next = state_reg;
			endcase
		end else if (sel_rise) begin
			state_next = S_IDLE;
			if (state_reg == S_TAIL && on_bound) begin
				case (op_reg)
					OP_WR_UNLOCK: wel_next = 1'b1;
					OP_WR_LOCK: wel_next = 1'b0;
					OP_WRAP_SET: begin
						wrap_next.wrap_off_bit = param_reg[WRAP_OFF_POS];
						wrap_next.wrap_len_hi  = param_reg[WRAP_HI_POS];
						wrap_next.wrap_len_lo  = param_reg[WRAP_LO_POS];
					end
					OP_READ_PARAM: begin
						wrap_next.wrap_len_hi = param_reg[PARAM_HI_POS];
						wrap_next.wrap_len_lo = param_reg[PARAM_LO_POS];
					end
					default: begin
						// erase accepted on the third address byte boundary
						if (wel_reg && op_reg == OP_SECT_CLEAR && !span_guarded(addr_reg, SECT_BITS, block_guard)) begin
							busy_next = 1'b1;
							kind_next = K_SECT;
							tmr_next  = SECT_CYC;
						end else if (wel_reg && op_reg == OP_BLK_CLEAR
						             && !span_guarded(addr_reg, BLK_BITS, block_guard)) begin
							busy_next = 1'b1;
							kind_next = K_BLK;
							tmr_next  = BLK_CYC;
						end
					end
				endcase
			end
			// program accepted only on a data byte boundary
			if (state_reg == S_DATA && on_bound && seen_reg && wel_reg
			    && (op_reg == OP_PAGE_WRITE || op_reg == OP_QUAD_WRITE)
			    && !guarded({addr_reg[23:8], 8'h00}, block_guard)) begin
				busy_next = 1'b1;
				kind_next = K_PROG;
				tmr_next  = PROG_CYC;
				sidx_next = 9'h0;
			end
			// erase span aligned to the sector or block
			if (busy_next && !busy_reg) begin
				aop_next.start = 1'b1;
				aop_next.kind  = kind_next;
				case (kind_next)
					K_SECT: aop_next.addr = addr_reg & ~24'((1 << SECT_BITS) - 1);
					K_BLK: aop_next.addr = addr_reg & ~24'((1 << BLK_BITS) - 1);
					default: aop_next.addr = {addr_reg[23:8], 8'h00};
				endcase
			end
		end

		// timed cycle; the latch drops one cycle before the busy flag
		if (busy_reg) begin
			tmr_next = tmr_reg - 32'h1;
			if (tmr_reg == 32'h2) begin
				wel_next = 1'b0;
			end
			// busy flag ends with the count
			if (tmr_reg == 32'h1) begin
				busy_next = 1'b0;
			end
			// only marked bytes reach the array
			if (kind_reg == K_PROG && !sidx_reg[8]) begin
				rd_live_next = 1'b1;
				rd_idx_next  = sidx_reg[7:0];
				sidx_next    = sidx_reg + 9'h1;
			end
		end
		if (rd_live_reg) begin
			pwe_next  = mask_reg[rd_idx_reg];
			padr_next = {aop_reg.addr[23:8], rd_idx_reg};
		end
	end

	// ====================================================
	// state registers
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg   <= S_IDLE;
			shift_reg   <= 8'h00;
			bit_reg     <= 3'h0;
			op_reg      <= 8'h00;
			addr_reg    <= 24'h000000;
			acnt_reg    <= 2'h0;
			ofs_reg     <= 8'h00;
			seen_reg    <= 1'b0;
			param_reg   <= 8'h00;
			mask_reg    <= '0;
			wel_reg     <= 1'b0;
			busy_reg    <= 1'b0;
			kind_reg    <= K_PROG;
			tmr_reg     <= 32'h0;
			sidx_reg    <= 9'h100;
			rd_live_reg <= 1'b0;
			rd_idx_reg  <= 8'h00;
			wrap_reg    <= '{wrap_off_bit: WRAP_OFF_RST, wrap_len_hi: WRAP_LEN_RST[1],
			                 wrap_len_lo: WRAP_LEN_RST[0]};
			aop_reg     <= '{start: 1'b0, kind: K_PROG, addr: 24'h000000};
			pwe_reg     <= 1'b0;
			padr_reg    <= 24'h000000;
		end else begin
			state_reg   <= state_next;
			shift_reg   <= shift_next;
			bit_reg     <= bit_next;
			op_reg      <= op_next;
			addr_reg    <= addr_next;
			acnt_reg    <= acnt_next;
			ofs_reg     <= ofs_next;
			seen_reg    <= seen_next;
			param_reg   <= param_next;
			mask_reg    <= mask_next;
			wel_reg     <= wel_next;
			busy_reg    <= busy_next;
			kind_reg    <= kind_next;
			tmr_reg     <= tmr_next;
			sidx_reg    <= sidx_next;
			rd_live_reg <= rd_live_next;
			rd_idx_reg  <= rd_idx_next;
			wrap_reg    <= wrap_next;
			aop_reg     <= aop_next;
			pwe_reg     <= pwe_next;
			padr_reg    <= padr_next;
		end
	end

	// ====================================================
	// page data; read data is registered so it lines up with prog_we
	page_buf #(
		.WIDTH (8),
		.DEPTH (PAGE_BYTES)
	) u_page (
		.mclk    (mclk),
		.rst_b   (rst_b),
		.wr_en   (buf_we),
		.wr_addr (buf_wa),
		.wr_data (shifted),
		.rd_addr (rd_idx_reg),
		.rd_data (prog_data)
	);

	// ====================================================
	// outputs, all from registers
	// wrap setting held for the read engine
	assign wrap_cfg         = wrap_reg;
	assign write_latch_flag = wel_reg;
	assign op_in_progress   = busy_reg;
	assign array_op         = aop_reg;
	assign prog_we          = pwe_reg;
	assign prog_addr        = padr_reg;
endmodule

// [design/flash_seq_pkg.sv]
// shared constants and types for the flash command sequencer
package flash_seq_pkg;

	// ====================================================
	// opcodes
	localparam logic [7:0] OP_WRAP_SET   = 8'h77;
	localparam logic [7:0] OP_PAGE_WRITE = 8'h02;
	localparam logic [7:0] OP_QUAD_WRITE = 8'h32;
	localparam logic [7:0] OP_SECT_CLEAR = 8'h20;
	localparam logic [7:0] OP_BLK_CLEAR  = 8'h52;
	localparam logic [7:0] OP_WR_UNLOCK  = 8'h06;
	localparam logic [7:0] OP_WR_LOCK    = 8'h04;
	localparam logic [7:0] OP_READ_PARAM = 8'hC0;

	// ====================================================
	// frame layout and field positions
	localparam int ADDR_BYTES     = 3;
	localparam int PAGE_BYTES     = 256;
	localparam int WRAP_OFF_POS   = 4;
	localparam int WRAP_LO_POS    = 5;
	localparam int WRAP_HI_POS    = 6;
	localparam int PARAM_LO_POS   = 0;
	localparam int PARAM_HI_POS   = 1;
	localparam int SECT_BITS      = 12;
	localparam int BLK_BITS       = 15;
	localparam int GUARD_BIG_BITS = 16;

	// ====================================================
	// reset values
	localparam logic       WRAP_OFF_RST = 1'b1;
	localparam logic [1:0] WRAP_LEN_RST = 2'h0;

	// ====================================================
	// timing: clock rate and self-timed cycle lengths
	localparam int CLK_MHZ        = 100;
	localparam int PROG_TIME_US   = 700;
	localparam int SECT_TIME_US   = 100000;
	localparam int BLK_TIME_US    = 500000;
	localparam int PROG_CYC_DEF   = PROG_TIME_US * CLK_MHZ;
	localparam int SECT_CYC_DEF   = SECT_TIME_US * CLK_MHZ;
	localparam int BLK_CYC_DEF    = BLK_TIME_US * CLK_MHZ;

	// ====================================================
	// types
	typedef struct packed {
		logic       cs_b;
		logic       sclk;
		logic [3:0] io;
	} link_pins_t;

	typedef struct packed {
		logic       wrap_off_bit;
		logic       wrap_len_hi;
		logic       wrap_len_lo;
	} wrap_cfg_t;

	typedef enum logic [1:0] {
		K_PROG,
		K_SECT,
		K_BLK
	} op_kind_t;

	typedef struct packed {
		logic        start;
		op_kind_t    kind;
		logic [23:0] addr;
	} array_op_t;

endpackage

// [design/link_sync.sv]
// two-stage synchroniser and edge finder for the serial link pins
`timescale 1ns/10ps
module link_sync (
	input  wire logic                      mclk,
	input  wire logic                      rst_b,
	input  wire flash_seq_pkg::link_pins_t pins,
	output logic                           sclk_rise,
	output logic                           sel_fall,
	output logic                           sel_rise,
	output logic                           sel,
	output logic [3:0]                     io_s
);
	import flash_seq_pkg::*;

	link_pins_t meta_reg;
	link_pins_t sync_reg;
	link_pins_t last_reg;

	// ====================================================
	// first stage feeds only the second; edges come from stage two and three
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			meta_reg <= '{cs_b: 1'b1, sclk: 1'b0, io: 4'h0};
			sync_reg <= '{cs_b: 1'b1, sclk: 1'b0, io: 4'h0};
			last_reg <= '{cs_b: 1'b1, sclk: 1'b0, io: 4'h0};
		end else begin
			meta_reg <= pins;
			sync_reg <= meta_reg;
			last_reg <= sync_reg;
		end
	end

	assign sclk_rise = sync_reg.sclk & ~last_reg.sclk;
	assign sel_fall  = ~sync_reg.cs_b & last_reg.cs_b;
	assign sel_rise  = sync_reg.cs_b & ~last_reg.cs_b;
	assign sel       = ~sync_reg.cs_b;
	assign io_s      = sync_reg.io;
endmodule

// [design/page_buf.sv]
// page-sized data buffer with registered read port
`timescale 1ns/10ps
module page_buf #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 256
) (
	input  wire logic                     mclk,
	input  wire logic                     rst_b,
	input  wire logic                     wr_en,
	input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
	input  wire logic [WIDTH-1:0]         wr_data,
	input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
	output logic [WIDTH-1:0]              rd_data
);
	logic [WIDTH-1:0] mem [DEPTH];

	// ====================================================
	// storage has no reset; only the read register does
	always_ff @(posedge mclk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rd_data <= '0;
		end else begin
			rd_data <= mem[rd_addr];
		end
	end
endmodule

// [tb/flash_cmd_seq_props.sv]
// concurrent checks on the ports of the flash command sequencer
`timescale 1ns/10ps
module flash_cmd_seq_props
	import flash_seq_pkg::*;
#(
	parameter int unsigned PROG_CYC = 300,
	parameter int unsigned SECT_CYC = 50,
	parameter int unsigned BLK_CYC  = 50
) (
	input wire logic       mclk,
	input wire logic       rst_b,
	input wire link_pins_t link_pins,
	input wire logic       write_latch_flag,
	input wire logic       op_in_progress,
	input wire array_op_t  array_op,
	input wire logic       prog_we,
	input wire logic [23:0] prog_addr
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	logic [31:0] busy_cnt_reg;
	logic [31:0] busy_cnt_next;
	logic [31:0] cyc_exp;
	// ====================================================
	// busy length counter, restarted by each start pulse
	always_comb begin
		busy_cnt_next = busy_cnt_reg;
		if (array_op.start)
			busy_cnt_next = 32'h1;
		else if (op_in_progress)
			busy_cnt_next = busy_cnt_reg + 32'h1;
		cyc_exp = (array_op.kind == K_PROG) ? PROG_CYC : (array_op.kind == K_SECT) ? SECT_CYC : BLK_CYC;
	end
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b)
			busy_cnt_reg <= 32'h0;
		else
			busy_cnt_reg <= busy_cnt_next;
	end
	// ====================================================
	// assertions
	AST_BUSY_LEN: assert property ($fell(op_in_progress) |-> busy_cnt_reg == cyc_exp)
		else $error("busy length wrong for this kind");
	AST_LATCH_BEFORE_END: assert property ($fell(op_in_progress) |-> !$past(write_latch_flag))
		else $error("write latch still set as busy ended");
	AST_RISE_HAS_START: assert property ($rose(op_in_progress) |-> array_op.start)
		else $error("busy rose without start pulse");
	AST_START_FROM_IDLE: assert property (array_op.start |-> $rose(op_in_progress))
		else $error("start pulse not at busy rise");
	AST_START_NEEDS_LATCH: assert property (array_op.start |-> write_latch_flag)
		else $error("cycle started without write latch");
	AST_START_PULSE: assert property (array_op.start |=> !array_op.start)
		else $error("start pulse longer than one cycle");
	AST_AFTER_RELEASE: assert property ($rose(op_in_progress) |-> link_pins.cs_b && $past(link_pins.cs_b, 2))
		else $error("cycle began before select release");
	AST_ALIGNED: assert property (array_op.start |-> (array_op.kind == K_PROG ? array_op.addr[7:0] == 8'h00 :
		array_op.kind == K_SECT ? array_op.addr[11:0] == 12'h000 : array_op.addr[14:0] == 15'h0000))
		else $error("target address not aligned");
	AST_WE_IN_PROG: assert property (prog_we |-> op_in_progress && array_op.kind == K_PROG)
		else $error("program strobe outside program cycle");
	AST_WE_SAME_PAGE: assert property (prog_we |-> prog_addr[23:8] == array_op.addr[23:8])
		else $error("program strobe left the page");
	AST_LATCH_IDLE: assert property ($rose(write_latch_flag) |-> !op_in_progress && link_pins.cs_b)
		else $error("write latch set during cycle or frame");
	cover property (array_op.start && array_op.kind == K_PROG);
	cover property (array_op.start && array_op.kind == K_SECT);
	cover property (array_op.start && array_op.kind == K_BLK);
endmodule
bind flash_cmd_seq flash_cmd_seq_props #(.PROG_CYC(PROG_CYC), .SECT_CYC(SECT_CYC), .BLK_CYC(BLK_CYC)) props_i (
	.mclk(mclk), .rst_b(rst_b), .link_pins(link_pins), .write_latch_flag(write_latch_flag),
	.op_in_progress(op_in_progress), .array_op(array_op), .prog_we(prog_we), .prog_addr(prog_addr));

// [tb/spi_host_model.sv]
// serial host model that shifts command frames into the sequencer
`timescale 1ns/10ps
module spi_host_model (
	output flash_seq_pkg::link_pins_t pins
);
	import flash_seq_pkg::*;
	// ====================================================
	// idle lines: select high, clock still, data flipping
	// bytes from this index on travel a nibble per clock on all four lines
	int wide_from = 1000;
	initial pins = {1'b1, 1'b0, 4'hA};
	always #80 if (pins.cs_b) pins.io = ~pins.io;
	// ====================================================
	// whole frame under select
	// msb first, data set while clock low; extra clocks model an early or late release
	task automatic send(input logic [7:0] b[$], input int extra);
		int n;
		int j;
		int w;
		n = extra;
		for (int i = 0; i < b.size(); i++)
			n += (i >= wide_from) ? 2 : 8;
		j = 0;
		#3 pins.cs_b = 1'b0;
		for (int i = 0; i < n; i++) begin
			w = (j / 8 >= wide_from) ? 4 : 1;
			#40;
			if (j / 8 >= b.size())
				pins.io[0] = ~pins.io[0];
			else if (w == 4)
				pins.io = b[j / 8][7 - j % 8 -: 4];
			else
				pins.io[0] = b[j / 8][7 - j % 8];
			j += w;
			#40 pins.sclk = 1'b1;
			#80 pins.sclk = 1'b0;
		end
		#80 pins.cs_b = 1'b1;
	endtask
endmodule

// [tb/flash_cmd_seq_bench.sv]
// self-checking bench for the flash command sequencer
`timescale 1ns/10ps
module flash_cmd_seq_bench;
	import flash_seq_pkg::*;
	localparam int P_CYC = 300;
	localparam int S_CYC = 50;
	localparam int B_CYC = 60;
	logic       mclk = 1'b0;
	logic       rst_b = 1'b0;
	logic       qe = 1'b0;
	logic       four_wire = 1'b0;
	logic [4:0] guard = 5'h00;
	link_pins_t pins;
	logic       latch;
	logic       busy;
	logic       we;
	wrap_cfg_t  wcfg;
	array_op_t  aop;
	array_op_t  last_op;
	logic [23:0] waddr;
	logic [7:0] wdata;
	logic [7:0] got[int];
	logic [7:0] exp[int];
	int         starts = 0;
	int         n_fail = 0;
	int         samples_checked = 0;
	int         seed = 51;
	always #5 mclk = ~mclk;
	flash_cmd_seq #(.PROG_CYC(P_CYC), .SECT_CYC(S_CYC), .BLK_CYC(B_CYC)) flash_cmd_seq_i (
		.mclk(mclk), .rst_b(rst_b), .link_pins(pins), .quad_enable_flag(qe), .four_wire_cmd_mode(four_wire),
		.block_guard(guard), .write_latch_flag(latch), .op_in_progress(busy), .wrap_cfg(wcfg),
		.array_op(aop), .prog_we(we), .prog_addr(waddr), .prog_data(wdata));
	spi_host_model spi_host_model_i (.pins(pins));
	// ====================================================
	// collect start pulses and program strobes mid-cycle, where they are settled
	always @(negedge mclk) begin
		if (aop.start) begin
			starts++;
			last_op = aop;
		end
		if (we)
			got[waddr] = wdata;
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic close_out();
		$display("comparisons=%0d mismatches=%0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// one frame; kind below zero means no cycle may follow
	task automatic run(input logic [7:0] b[$], input int extra, input int kind, input logic [23:0] a);
		int s0;
		int k;
		s0 = starts;
		got.delete();
		spi_host_model_i.send(b, extra);
		k = 0;
		while (busy !== 1'b1 && k < 20) begin
			@(negedge mclk);
			k++;
		end
		if (kind >= 0) begin
			k = 0;
			while (busy === 1'b1 && k < 1000) begin
				@(negedge mclk);
				k++;
			end
			if (k >= 1000) begin
				n_fail++;
				close_out();
			end
			chk(k, (kind == 0) ? P_CYC : (kind == 1) ? S_CYC : B_CYC);
			chk(latch, 1'b0);
			chk(last_op, {1'b1, kind[1:0], a});
		end
		// start count is read only after the cycle, once the collector has seen the pulse
		chk(starts - s0, (kind < 0) ? 0 : 1);
	endtask
	task automatic unlock();
		run({OP_WR_UNLOCK}, 0, -1, 24'h0);
		chk(latch, 1'b1);
	endtask
	// model: page offset wraps and the last byte written to an offset wins
	task automatic prog(input logic [7:0] op, input logic [23:0] a, input int n);
		logic [7:0] b[$];
		b = {op, a[23:16], a[15:8], a[7:0]};
		exp.delete();
		for (int i = 0; i < n; i++) begin
			b.push_back(8'($random(seed)));
			exp[{a[23:8], 8'(a[7:0] + i)}] = b[b.size() - 1];
		end
		unlock();
		run(b, 0, 0, {a[23:8], 8'h00});
		chk(got.size(), exp.size());
		foreach (exp[k])
			chk(got.exists(k) ? got[k] : ~exp[k], exp[k]);
	endtask
	initial begin
		#900000;
		n_fail++;
		close_out();
	end
	// ====================================================
	// main sequence
	initial begin
		repeat (20) @(negedge mclk);
		rst_b = 1'b1;
		repeat (3) @(negedge mclk);
		chk({latch, busy, wcfg}, {2'b00, WRAP_OFF_RST, WRAP_LEN_RST});
		run({OP_PAGE_WRITE, 8'h01, 8'h00, 8'h00, 8'h55}, 0, -1, 24'h0);
		for (int w = 0; w < 8; w++) begin
			run({OP_WRAP_SET, 8'h00, 8'h00, 8'h00, 8'(w << 4)}, 0, -1, 24'h0);
			chk(wcfg, {w[0], w[2], w[1]});
		end
		prog(OP_PAGE_WRITE, 24'h0345F0, 20);
		prog(OP_PAGE_WRITE, 24'h00F7A3, 260);
		prog(OP_PAGE_WRITE, 24'h120000 | 24'($random(seed) & 255), 1 + ($random(seed) & 7));
		unlock();
		run({OP_PAGE_WRITE, 8'h01, 8'h00, 8'h00, 8'hAA}, 3, -1, 24'h0);
		run({OP_SECT_CLEAR, 8'h12, 8'h34, 8'h56}, 5, -1, 24'h0);
		run({OP_QUAD_WRITE, 8'h01, 8'h00, 8'h00, 8'hAA}, 0, -1, 24'h0);
		chk(latch, 1'b1);
		run({OP_SECT_CLEAR, 8'h12, 8'h34, 8'h56}, 0, 1, 24'h123000);
		// quad program: opcode on one line, address and data a nibble per clock
		@(negedge mclk);
		qe = 1'b1;
		spi_host_model_i.wide_from = 1;
		prog(OP_QUAD_WRITE, 24'h0456C0 | 24'($random(seed) & 15), 6);
		spi_host_model_i.wide_from = 1000;
		@(negedge mclk);
		guard = 5'h07;
		unlock();
		run({OP_BLK_CLEAR, 8'h21, 8'hFF, 8'h01}, 0, -1, 24'h0);
		run({OP_PAGE_WRITE, 8'h21, 8'h00, 8'h00, 8'h5A}, 0, -1, 24'h0);
		@(negedge mclk);
		guard = 5'h00;
		run({OP_BLK_CLEAR, 8'h21, 8'hFF, 8'h01}, 0, 2, 24'h218000);
		// four-wire mode: every phase nibble wide; length changes, off bit kept
		@(negedge mclk);
		four_wire = 1'b1;
		spi_host_model_i.wide_from = 0;
		run({OP_READ_PARAM, 8'h02}, 0, -1, 24'h0);
		chk(wcfg, {1'b1, 2'b10});
		close_out();
	end
endmodule
